// File: core/aopc_port.sv
// What this block does
// - code select low inverts result msb
// - port select picks parallel or serial
// - low four data bits always driven
// - parallel mode drives shared pins bits 4-7
// - clock source: master drives, slave follows
// - sync polarity select sets frame sync level
// - clock invert flips serial clock, edges
// - result shifts out msb first
// - chain input follows after sixteen clocks
// - read mode: during or after conversion
module aopc_port
   import aopc_pkg::*;
#(
   parameter int W = RES_WIDTH
) (
   input  wire logic          i_clock,
   input  wire logic          i_rst,
   input  wire logic [W-1:0]  i_result_data,
   input  wire logic          i_result_valid,
   input  wire logic          i_conv_start,
   input  wire logic          i_output_code_select,
   input  wire logic          i_port_type_select,
   input  wire logic [3:0]    i_shared_pin,
   input  wire logic          i_sclk,
   input  wire logic          i_chip_select_n,
   output logic [3:0]         o_data_low,
   output logic [3:0]         o_shared_pin,
   output logic [3:0]         o_shared_oe_n,
   output logic [15:8]        o_data_high,
   output logic               o_sclk,
   output logic               o_sclk_oe_n,
   output logic               o_frame_sync
);

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);

   // pin synchronisers
   aopc_pins_s  pins_raw;
   aopc_pins_s  s1_r;
   aopc_pins_s  s2_r;
   logic        sclk_d_r;
   logic        cs_d_r;

   assign pins_raw = '{output_code_select: i_output_code_select,
                       port_type_select:   i_port_type_select,
                       shared_pin:         i_shared_pin,
                       sclk:               i_sclk,
                       chip_select_n:      i_chip_select_n};

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         s1_r     <= '0;
         s2_r     <= '0;
         sclk_d_r <= 1'b0;
         cs_d_r   <= 1'b1;
      end else begin
         s1_r     <= pins_raw;
         s2_r     <= s1_r;
         sclk_d_r <= s2_r.sclk;
         cs_d_r   <= s2_r.chip_select_n;
      end
   end

   // configuration decode
   aopc_cfg_s cfg_r;
   aopc_cfg_s cfg_nxt;

   always_comb begin
      cfg_nxt.code_binary = s2_r.output_code_select;
      cfg_nxt.serial      = s2_r.port_type_select;
      cfg_nxt.ext_clock   = s2_r.port_type_select & s2_r.shared_pin[PIN_CLK_SRC];
      cfg_nxt.sync_low    = s2_r.port_type_select & s2_r.shared_pin[PIN_SYNC_POL];
      cfg_nxt.clk_inv     = s2_r.port_type_select & s2_r.shared_pin[PIN_CLK_INV];
      cfg_nxt.rd_during   = s2_r.port_type_select & s2_r.shared_pin[PIN_RD_CHAIN];
   end

   // result holding register and parallel outputs
   logic [W-1:0] res_r;
   logic [W-1:0] res_nxt;
   logic         res_load_r;
   logic [3:0]   oe_n_r;
   logic [3:0]   oe_n_nxt;
   logic [15:8]  high_r;
   logic [15:8]  high_nxt;
   logic         ser_bit;

   always_comb begin
      res_nxt = res_r;
      if (i_result_valid) begin
         res_nxt = {i_result_data[W-1] ^ ~cfg_r.code_binary, i_result_data[W-2:0]};
      end
      oe_n_nxt = cfg_r.serial ? OE_N_OFF : OE_N_ON;
      high_nxt = cfg_r.serial ? {7'h00, ser_bit} : res_r[15:8];
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cfg_r      <= '0;
         res_r      <= RESULT_RST;
         res_load_r <= 1'b0;
         oe_n_r     <= OE_N_OFF;
         high_r     <= RESULT_RST[15:8];
      end else begin
         cfg_r      <= cfg_nxt;
         res_r      <= res_nxt;
         res_load_r <= i_result_valid;
         oe_n_r     <= oe_n_nxt;
         high_r     <= high_nxt;
      end
   end

   assign o_data_low    = res_r[3:0];
   assign o_shared_pin  = res_r[7:4];
   assign o_shared_oe_n = oe_n_r;
   assign o_data_high   = high_r;

   // master serial sequencer
   aopc_state_e state_r;
   aopc_state_e st_nxt;
   logic [3:0]  div_r;
   logic [3:0]  div_nxt;
   logic        phase_r;
   logic        ph_nxt;
   logic        sclk_r;
   logic        sclk_oe_n_r;
   logic        fs_r;
   logic        m_load;
   logic        m_shift;
   logic        start_m;
   logic        tick;
   logic [4:0]  bit_count;

   assign start_m = cfg_r.serial & ~cfg_r.ext_clock
                  & (cfg_r.rd_during ? i_conv_start : res_load_r);
   assign tick    = (div_r == MSCLK_HALF_CYC - 4'h1);

   always_comb begin
      st_nxt  = state_r;
      div_nxt = div_r;
      ph_nxt  = phase_r;
      m_load  = 1'b0;
      m_shift = 1'b0;
      case (state_r)
         ST_IDLE: begin
            div_nxt = 4'h0;
            ph_nxt  = 1'b0;
            if (start_m) begin
               st_nxt = ST_SYNC;
               m_load = 1'b1;
            end
         end
         ST_SYNC: begin
            div_nxt = tick ? 4'h0 : div_r + 4'h1;
            if (tick) begin
               st_nxt = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            div_nxt = tick ? 4'h0 : div_r + 4'h1;
            if (tick) begin
               ph_nxt = ~phase_r;
               if (phase_r) begin
                  m_shift = 1'b1;
                  if (bit_count == FRAME_LAST) begin
                     st_nxt = ST_IDLE;
                  end
               end
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
      if (!cfg_r.serial || cfg_r.ext_clock) begin
         st_nxt = ST_IDLE;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state_r     <= ST_IDLE;
         div_r       <= 4'h0;
         phase_r     <= 1'b0;
         sclk_r      <= 1'b0;
         sclk_oe_n_r <= 1'b1;
         fs_r        <= 1'b0;
      end else begin
         state_r     <= st_nxt;
         div_r       <= div_nxt;
         phase_r     <= ph_nxt;
         sclk_r      <= ph_nxt ^ cfg_r.clk_inv;
         sclk_oe_n_r <= ~(cfg_r.serial & ~cfg_r.ext_clock);
         fs_r        <= (st_nxt != ST_IDLE) ^ cfg_r.sync_low;
      end
   end

   assign o_sclk       = sclk_r;
   assign o_sclk_oe_n  = sclk_oe_n_r;
   assign o_frame_sync = fs_r;

   // slave serial on external clock
   logic s_mode;
   logic s_load;
   logic s_edge;

   assign s_mode = cfg_r.serial & cfg_r.ext_clock;
   assign s_load = s_mode & ~s2_r.chip_select_n & cs_d_r;
   assign s_edge = s_mode & ~s2_r.chip_select_n
                 & (cfg_r.clk_inv ? (~s2_r.sclk & sclk_d_r) : (s2_r.sclk & ~sclk_d_r));

   aopc_shifter #(
      .W (W)
   ) u_shifter (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_load  (m_load | s_load),
      .i_data  (res_r),
      .i_shift (m_shift | s_edge),
      .i_chain (s2_r.shared_pin[PIN_RD_CHAIN]),
      .o_bit   (ser_bit),
      .o_count (bit_count)
   );

   code_msb_a : assert property (
      i_result_valid |=> res_r[W-1] ==
         ($past(i_result_data[W-1]) ^ ~$past(cfg_r.code_binary)))
      else $error("result msb coding wrong");

   low_bits_a : assert property (
      i_result_valid |=> o_data_low == $past(i_result_data[3:0]))
      else $error("low data bits not driven");

   par_bus_a : assert property (
      !cfg_r.serial && $stable(cfg_r.serial) |=> o_shared_oe_n == OE_N_ON)
      else $error("shared pins not driven in parallel mode");

   serial_pins_a : assert property (
      cfg_r.serial && $stable(cfg_r.serial) |=>
         (o_shared_oe_n == OE_N_OFF) && (o_data_high[15:9] == 7'h00))
      else $error("serial mode pins wrong");

   clk_drive_a : assert property (
      cfg_r.serial && $stable(cfg_r) |=> o_sclk_oe_n == $past(cfg_r.ext_clock))
      else $error("serial clock drive wrong");

   sync_pol_a : assert property (
      start_m && state_r == ST_IDLE |=> (o_frame_sync == ~cfg_r.sync_low) [*3])
      else $error("frame sync level wrong");

   clk_idle_a : assert property (
      state_r == ST_IDLE && !start_m && $stable(cfg_r) |=> o_sclk == $past(cfg_r.clk_inv))
      else $error("idle serial clock level wrong");

   frame_len_a : assert property (
      start_m && state_r == ST_IDLE ##1 $stable(cfg_r) |=>
         ##97 (state_r == ST_SHIFT) ##1 (state_r == ST_IDLE))
      else $error("master frame length wrong");

   read_mode_a : assert property (
      state_r == ST_IDLE && cfg_r.serial && !cfg_r.ext_clock
         && cfg_r.rd_during && i_conv_start |=> state_r == ST_SYNC)
      else $error("read during conversion did not start");

endmodule : aopc_port

// File: core/aopc_shifter.sv
module aopc_shifter
   import aopc_pkg::*;
#(
   parameter int W  = RES_WIDTH,
   parameter int CW = $clog2(W + 1)
) (
   input  wire logic          i_clock,
   input  wire logic          i_rst,
   input  wire logic          i_load,
   input  wire logic [W-1:0]  i_data,
   input  wire logic          i_shift,
   input  wire logic          i_chain,
   output logic               o_bit,
   output logic [CW-1:0]      o_count
);

   localparam logic [CW-1:0] CNT_MAX = CW'(W);

   logic [W-1:0]  shreg_r;
   logic [W-1:0]  shreg_nxt;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;

   always_comb begin
      shreg_nxt = shreg_r;
      cnt_nxt   = cnt_r;
      if (i_load) begin
         shreg_nxt = i_data;
         cnt_nxt   = '0;
      end else if (i_shift) begin
         shreg_nxt = {shreg_r[W-2:0], i_chain};
         cnt_nxt   = (cnt_r == CNT_MAX) ? CNT_MAX : cnt_r + 1'b1;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         shreg_r <= '0;
         cnt_r   <= '0;
      end else begin
         shreg_r <= shreg_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   assign o_bit   = shreg_r[W-1];
   assign o_count = cnt_r;

   msb_first_a : assert property (
      @(posedge i_clock) disable iff (i_rst)
      i_load |=> (o_bit == $past(i_data[W-1])) && (o_count == '0))
      else $error("first serial bit is not the msb");

   chain_in_a : assert property (
      @(posedge i_clock) disable iff (i_rst)
      (i_shift && !i_load) |=> (shreg_r[0] == $past(i_chain))
         && (o_bit == $past(shreg_r[W-2])))
      else $error("shift did not take the chain bit");

endmodule : aopc_shifter

// File: dv/aopc_host.sv
module aopc_host
   import aopc_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_ext,
   input  wire logic        i_inv,
   input  wire logic        i_start,
   input  wire logic        i_dout,
   input  wire logic        i_msclk,
   input  wire logic [15:0] i_chain_word,
   output logic             o_sclk,
   output logic             o_cs_n,
   output logic             o_chain,
   output logic [31:0]      o_word,
   output int               o_bits
);
   timeunit 1ns;
   timeprecision 100ps;

   logic prev_r = 1'b0;

   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_chain = 1'b0;
   end

   always @(posedge i_clock) begin
      if (i_start) begin
         o_word <= '0;
         o_bits <= 0;
      end else if (!i_ext && prev_r == i_inv && i_msclk != i_inv) begin
         o_word <= {o_word[30:0], i_dout};
         o_bits <= o_bits + 1;
      end
      prev_r <= i_msclk;
   end

   always @(negedge i_start) begin
      if (i_ext) begin
         #3;
         o_sclk = i_inv;
         o_cs_n = 1'b0;
         #500;
         for (int i = 0; i < 32; i++) begin
            o_word = {o_word[30:0], i_dout};
            o_bits++;
            o_chain = (i < 16) ? i_chain_word[15 - i] : ~o_chain;
            #62.5;
            o_sclk = ~i_inv;
            #62.5;
            o_sclk = i_inv;
         end
         o_cs_n = 1'b1;
         o_chain = ~o_chain;
      end
   end
endmodule : aopc_host

// File: dv/aopc_port_bench.sv
module aopc_port_bench
   import aopc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clock = 1'b0, rst = 1'b1, valid = 1'b0, conv = 1'b0;
   logic        code = 1'b1, ser = 1'b0, start = 1'b0;
   logic [15:0] data = '0, chain_word = '0, d;
   logic [3:0]  strap = '0, pin_w, low_o, sp_o, sp_oe_n;
   logic [15:8] high_o;
   logic        msclk, msclk_oe_n, sync_o, hsclk, cs_n, chain;
   logic [31:0] word;
   int          bits, errors = 0, cmp_count = 0, cycles = 0, seed = 44;

   always #5 clock = ~clock;
   // shared pads: own drive when enabled, else strap or chain level
   assign pin_w = (~sp_oe_n & sp_o) | (sp_oe_n & {strap[0] ? chain : strap[3], strap[2:0]});

   aopc_port dut (.i_clock(clock), .i_rst(rst), .i_result_data(data),
      .i_result_valid(valid), .i_conv_start(conv), .i_output_code_select(code),
      .i_port_type_select(ser), .i_shared_pin(pin_w), .i_sclk(hsclk),
      .i_chip_select_n(cs_n), .o_data_low(low_o), .o_shared_pin(sp_o),
      .o_shared_oe_n(sp_oe_n), .o_data_high(high_o), .o_sclk(msclk),
      .o_sclk_oe_n(msclk_oe_n), .o_frame_sync(sync_o));

   aopc_host host (.i_clock(clock), .i_ext(strap[0]), .i_inv(strap[2]), .i_start(start),
      .i_dout(high_o[8]), .i_msclk(msclk), .i_chain_word(chain_word), .o_sclk(hsclk),
      .o_cs_n(cs_n), .o_chain(chain), .o_word(word), .o_bits(bits));

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask : cyc

   task automatic send(input logic [15:0] v, input logic two);
      valid = 1'b1;
      if (two) begin
         data = 16'($random(seed));
         cyc(1);
      end
      data = v;
      cyc(1);
      valid = 1'b0;
   endtask : send

   task automatic pulse_start;
      start = 1'b1;
      cyc(1);
      start = 1'b0;
   endtask : pulse_start

   function automatic logic [15:0] coded(input logic [15:0] v, input logic c);
      return c ? v : v ^ 16'h8000;
   endfunction : coded

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         report_and_stop();
      end
   end

   initial begin
      cyc(3);
      chk("oe_n in reset", 32'h0000_000f, 32'(sp_oe_n));
      cyc(4);
      rst = 1'b0;
      for (int k = 0; k < 6; k++) begin
         code = k[0];
         d = (k < 2) ? 16'h8000 : (k < 4) ? 16'h7fff : 16'($random(seed));
         cyc(6);
         send(d, 1'b1);
         cyc(3);
         chk("data_low", 32'(coded(d, code) & 16'h000f), 32'(low_o));
         chk("shared out", 32'(coded(d, code) >> 4 & 16'h000f), 32'(sp_o));
         chk("shared oe_n", 32'h0000_0000, 32'(sp_oe_n));
         chk("data_high", 32'(coded(d, code) >> 8), 32'(high_o));
      end
      ser = 1'b1;
      for (int k = 0; k < 4; k++) begin
         strap = {k[0], k[1], 1'($random(seed)), 1'b0};
         code = 1'($random(seed));
         d = 16'($random(seed));
         cyc(6);
         pulse_start();
         if (strap[3]) send(d, 1'b0);
         else conv = 1'b1;
         cyc(1);
         conv = 1'b0;
         cyc(10);
         chk("early bits", 32'h0000_0000, 32'(bits));
         if (strap[3]) conv = 1'b1;
         else send(d, 1'b0);
         cyc(1);
         conv = 1'b0;
         cyc(50);
         chk("sync active", 32'(!strap[1]), 32'(sync_o));
         chk("sclk oe_n", 32'h0000_0000, 32'(msclk_oe_n));
         chk("serial oe_n", 32'h0000_000f, 32'(sp_oe_n));
         cyc(60);
         chk("sync idle", 32'(strap[1]), 32'(sync_o));
         chk("bit count", 32'h0000_0010, 32'(bits));
         chk("master word", 32'(coded(d, code)), 32'(word[15:0]));
      end
      for (int k = 0; k < 4; k++) begin
         strap = {1'b0, k[0], k[1], 1'b1};
         chain_word = 16'($random(seed));
         d = 16'($random(seed));
         cyc(6);
         send(d, k[1]);
         pulse_start();
         cyc(8);
         chk("slave sync", 32'(strap[1]), 32'(sync_o));
         chk("slave oe_n", 32'h0000_0001, 32'(msclk_oe_n));
         // straps stay put until the host deselects
         for (int t = 0; t < 600 && (bits < 32 || !cs_n); t++) cyc(1);
         chk("chain word", {coded(d, code), chain_word}, word);
      end
      report_and_stop();
   end
endmodule : aopc_port_bench

// File: inc/aopc_pkg.sv
package aopc_pkg;

   // result and frame geometry
   localparam int           RES_WIDTH    = 16;
   localparam int           SHARED_WIDTH = 4;
   localparam int           FRAME_BITS   = 16;
   localparam logic [4:0]   FRAME_LAST   = 5'h0f;

   // shared pin positions while in serial mode
   localparam int           PIN_CLK_SRC  = 0;
   localparam int           PIN_SYNC_POL = 1;
   localparam int           PIN_CLK_INV  = 2;
   localparam int           PIN_RD_CHAIN = 3;

   // master serial clock timing
   localparam int           CLOCK_NS        = 10;
   localparam int           MSCLK_PERIOD_NS = 60;
   localparam logic [3:0]   MSCLK_HALF_CYC  =
      4'(((MSCLK_PERIOD_NS / 2) + CLOCK_NS - 1) / CLOCK_NS);

   // reset values and output enable levels
   localparam logic [15:0]  RESULT_RST   = 16'h0000;
   localparam logic [3:0]   OE_N_OFF     = 4'hf;
   localparam logic [3:0]   OE_N_ON      = 4'h0;

   typedef struct packed {
      logic       output_code_select;
      logic       port_type_select;
      logic [3:0] shared_pin;
      logic       sclk;
      logic       chip_select_n;
   } aopc_pins_s;

   typedef struct packed {
      logic code_binary;
      logic serial;
      logic ext_clock;
      logic sync_low;
      logic clk_inv;
      logic rd_during;
   } aopc_cfg_s;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SYNC  = 3'b010,
      ST_SHIFT = 3'b100
   } aopc_state_e;

endpackage : aopc_pkg
